// *** src/brightness_pkg.sv ***
// Constants shared by the single-wire brightness control block
package brightness_pkg;
  // Core clock period in ns and derived microsecond tick
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned NS_PER_US = 1000;
  localparam int unsigned US_TICK_CYCLES = (NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Pin timing, in microseconds
  localparam int unsigned POWER_ON_WAIT_TIME_US = 140;
  localparam int unsigned SLEEP_ENTRY_LOW_TIME_US = 1260;
  localparam int unsigned DIRECTION_RAISE_LOW_MIN_US = 100;
  localparam int unsigned DIRECTION_RAISE_LOW_MAX_US = 160;
  localparam int unsigned DIRECTION_LOWER_LOW_MIN_US = 420;
  localparam int unsigned DIRECTION_LOWER_LOW_MAX_US = 500;
  localparam int unsigned PRE_DIRECTION_HIGH_WAIT_US = 140;
  localparam int unsigned PRESET_FIRST_EDGE_WINDOW_MIN_US = 35;
  localparam int unsigned PRESET_FIRST_EDGE_WINDOW_MAX_US = 50;
  // Phase timer width in bits; the timer counts microseconds
  localparam int unsigned PHASE_W = 11;
  // Brightness counter
  localparam int unsigned LEVEL_W = 4;
  localparam logic [3:0] LEVEL_RESET = 4'hf;
  localparam int unsigned CODE_W = 8;
  // Log-spaced current codes, ratio near two to the third root
  localparam logic [7:0] CURRENT_CODE [16] = '{
    8'h08, 8'h0a, 8'h0d, 8'h10, 8'h14, 8'h19, 8'h20, 8'h28,
    8'h32, 8'h3f, 8'h50, 8'h65, 8'h7f, 8'ha0, 8'hca, 8'hff
  };
  // Link states
  typedef enum logic [2:0] {
    ST_SLEEP,
    ST_SETUP,
    ST_PRESET,
    ST_ACTIVE
  } link_state_e;
endpackage

// *** src/pulse_meter_if.sv ***
// Edge and phase timing signals shared inside the block
`timescale 1ns/1ps
`default_nettype none
interface pulse_meter_if #(parameter int unsigned PW = 11);
  logic us_tick;
  logic fall;
  logic rise;
  logic [PW-1:0] phase_us;
  modport tick_src (output us_tick);
  modport meter (input us_tick, output fall, output rise, output phase_us);
  modport user (input us_tick, input fall, input rise, input phase_us);
endinterface
`default_nettype wire

// *** src/us_timebase.sv ***
// Free-running microsecond tick generator
`timescale 1ns/1ps
`default_nettype none
module us_timebase #(
  parameter int unsigned TICK_CYCLES = brightness_pkg::US_TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  pulse_meter_if.tick_src tb
);
  import brightness_pkg::*;
  localparam int unsigned TW = $clog2(TICK_CYCLES);
  localparam logic [TW-1:0] LAST = TW'(TICK_CYCLES - 1);
  logic [TW-1:0] div;
  wire wrap = (div == LAST);
  // Prescaler runs on every rising edge, never stopped
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      div <= '0;
    end else begin
      div <= wrap ? '0 : div + 1'b1; // R26
    end
  end
  assign tb.us_tick = wrap;
endmodule
`default_nettype wire

// *** src/pin_phase_meter.sv ***
// Edge detector and phase length timer for the control pin
`timescale 1ns/1ps
`default_nettype none
module pin_phase_meter #(
  parameter int unsigned PW = brightness_pkg::PHASE_W
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic serial_control_pin,
  pulse_meter_if.meter pm
);
  import brightness_pkg::*;
  logic pin_q;
  logic [PW-1:0] phase;
  wire edge_seen = serial_control_pin ^ pin_q;
  wire sat = &phase;
  // Edges against the last sampled level
  assign pm.fall = pin_q & ~serial_control_pin;
  assign pm.rise = serial_control_pin & ~pin_q;
  assign pm.phase_us = phase;
  // Phase restarts on each edge, saturates when long
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pin_q <= 1'b0;
      phase <= '0;
    end else begin
      pin_q <= serial_control_pin;
      if (edge_seen) begin
        phase <= '0;
      end else if (pm.us_tick && !sat) begin
        phase <= phase + 1'b1; // R26
      end
    end
  end
endmodule
`default_nettype wire

// *** src/brightness_link.sv ***
// Single-wire brightness and shutdown control, top level
`timescale 1ns/1ps
`default_nettype none
// What this block does, and what it expects of the controller
// R1: Level moves only on falling edges; other changes depend on phase length.
// R2: Powered with pin low, the block sits in shutdown.
// R3: Without preset, LEDs turn on after pin high for 140 us.
// R4: Default start-up is level 15, counting down.
// R5: Edges in the setup window lower the starting level.
// R6: Pin low for 1260 us or more forces shutdown.
// R7: Shutdown drops boost and LEDs and forgets level and direction.
// R8: Low of 100 to 160 us selects counting up.
// R9: Low of 420 to 500 us selects counting down.
// R10: Controller keeps programming high and low phases within 1 to 32 us.
// R11: First falling edge after start-up or direction change is ignored; the block counts the first fall after a direction pulse.
// R12: Each counted falling edge moves the level by one.
// R13: Controller holds pin high 140 us before a direction pulse.
// R14: Pulse bursts step once per counted edge.
// R15: Steady high pin keeps the level with no further activity.
// R16: Brightness is a 0 to 15 up/down counter.
// R17: Counting down from 0 wraps to 15.
// R18: Counting up from 15 wraps to 0.
// R19: Lower-direction pulse then one edge gives exactly one step down.
// R20: Raise-direction pulse then one edge gives exactly one step up.
// R21: Sixteen logarithmically spaced current levels are provided.
// R22: Controller places the first preset edge 35 to 50 us after rising.
// R23: Presetting counts down, ignores no edge, takes no direction change.
// R24: After presetting, LEDs wait for pin high for 140 us.
// R25: Low phases of other lengths are plain edges; direction kept.
// R26: Phase lengths are timed with a free-running microsecond base.
module brightness_link #(
  parameter int unsigned SLEEP_US = brightness_pkg::SLEEP_ENTRY_LOW_TIME_US,
  parameter int unsigned ON_WAIT_US = brightness_pkg::POWER_ON_WAIT_TIME_US,
  parameter int unsigned DELAY_US = brightness_pkg::PRE_DIRECTION_HIGH_WAIT_US,
  parameter int unsigned UP_MIN_US = brightness_pkg::DIRECTION_RAISE_LOW_MIN_US,
  parameter int unsigned UP_MAX_US = brightness_pkg::DIRECTION_RAISE_LOW_MAX_US,
  parameter int unsigned DN_MIN_US = brightness_pkg::DIRECTION_LOWER_LOW_MIN_US,
  parameter int unsigned DN_MAX_US = brightness_pkg::DIRECTION_LOWER_LOW_MAX_US,
  parameter int unsigned WIN_MIN_US = brightness_pkg::PRESET_FIRST_EDGE_WINDOW_MIN_US,
  parameter int unsigned WIN_MAX_US = brightness_pkg::PRESET_FIRST_EDGE_WINDOW_MAX_US,
  parameter int unsigned TICK_CYCLES = brightness_pkg::US_TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic serial_control_pin,
  output logic boost_enable,
  output logic led_drive_enable,
  output logic count_up,
  output logic [brightness_pkg::LEVEL_W-1:0] brightness_level,
  output logic [brightness_pkg::CODE_W-1:0] led_current_code
);
  import brightness_pkg::*;

  // ----------------------------------------
  // Limits at phase timer width
  // ----------------------------------------
  localparam logic [PHASE_W-1:0] SLEEP_LIM = PHASE_W'(SLEEP_US);
  localparam logic [PHASE_W-1:0] ON_LIM = PHASE_W'(ON_WAIT_US);
  localparam logic [PHASE_W-1:0] DELAY_LIM = PHASE_W'(DELAY_US);
  localparam logic [PHASE_W-1:0] UP_MIN = PHASE_W'(UP_MIN_US);
  localparam logic [PHASE_W-1:0] UP_MAX = PHASE_W'(UP_MAX_US);
  localparam logic [PHASE_W-1:0] DN_MIN = PHASE_W'(DN_MIN_US);
  localparam logic [PHASE_W-1:0] DN_MAX = PHASE_W'(DN_MAX_US);
  localparam logic [PHASE_W-1:0] WIN_MIN = PHASE_W'(WIN_MIN_US);
  localparam logic [PHASE_W-1:0] WIN_MAX = PHASE_W'(WIN_MAX_US);

  // ----------------------------------------
  // Timebase and pin meter
  // ----------------------------------------
  pulse_meter_if #(.PW(PHASE_W)) pm ();

  us_timebase #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timebase (
    .core_clk(core_clk),
    .nrst(nrst),
    .tb(pm.tick_src)
  );

  pin_phase_meter #(
    .PW(PHASE_W)
  ) u_meter (
    .core_clk(core_clk),
    .nrst(nrst),
    .serial_control_pin(serial_control_pin),
    .pm(pm.meter)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  link_state_e state;
  link_state_e next_state;
  logic [LEVEL_W-1:0] level;
  logic [LEVEL_W-1:0] next_level;
  logic dir_up;
  logic next_dir_up;
  logic skip_first;
  logic next_skip_first;

  // ----------------------------------------
  // Phase decode
  // ----------------------------------------
  wire pin_low = ~serial_control_pin;
  wire pin_high = serial_control_pin;
  wire fall = pm.fall;
  wire rise = pm.rise;
  wire [PHASE_W-1:0] phase = pm.phase_us;
  // Long low forces shutdown; the fall cycle still shows the high length
  wire long_low = pin_low && !fall && (phase >= SLEEP_LIM); // R6
  // Completed low phase lengths, valid with rise
  wire up_pulse = rise && (phase >= UP_MIN) && (phase <= UP_MAX); // R8
  wire dn_pulse = rise && (phase >= DN_MIN) && (phase <= DN_MAX); // R9
  // High phase long enough to start driving; rise cycle shows the low length
  wire on_ready = pin_high && !rise && (phase >= ON_LIM); // R3
  // Settled high re-arms the skip; a direction low must not
  wire rearm = pin_high && !rise && (phase >= DELAY_LIM); // R19 R20
  // First preset edge inside the window after rising
  wire in_window = fall && (phase >= WIN_MIN) && (phase <= WIN_MAX); // R5

  wire is_sleep = (state == ST_SLEEP);
  wire is_setup = (state == ST_SETUP);
  wire is_preset = (state == ST_PRESET);
  wire is_active = (state == ST_ACTIVE);

  // Counted edge: presetting never skips, normal mode skips once
  wire step_active = is_active && fall && !skip_first; // R11
  wire step_preset = (is_setup && in_window) || (is_preset && fall); // R23
  wire step = step_active || step_preset; // R1 R14
  // Presetting always counts down
  wire step_up = step_active && dir_up; // R23
  wire [LEVEL_W-1:0] level_inc = level + 1'b1; // R18
  wire [LEVEL_W-1:0] level_dec = level - 1'b1; // R17

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_SLEEP: begin
        if (rise) begin
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (in_window) begin
          next_state = ST_PRESET; // R5
        end else if (on_ready) begin
          next_state = ST_ACTIVE; // R3
        end
      end
      ST_PRESET: begin
        if (on_ready) begin
          next_state = ST_ACTIVE; // R24
        end
      end
      ST_ACTIVE: begin
        next_state = ST_ACTIVE;
      end
      default: begin
        next_state = ST_SLEEP;
      end
    endcase
    if (long_low) begin
      next_state = ST_SLEEP; // R6
    end
  end

  // Level: reset to full in shutdown, else step on counted edges
  always_comb begin
    next_level = level;
    if (next_state == ST_SLEEP) begin
      next_level = LEVEL_RESET; // R7
    end else if (step) begin
      next_level = step_up ? level_inc : level_dec; // R12
    end
  end

  // Direction: forced down in shutdown, set by long low phases
  always_comb begin
    next_dir_up = dir_up; // R25
    if (next_state == ST_SLEEP) begin
      next_dir_up = 1'b0; // R4
    end else if (is_active && up_pulse) begin
      next_dir_up = 1'b1; // R8
    end else if (is_active && dn_pulse) begin
      next_dir_up = 1'b0; // R9
    end
  end

  // Ignore flag: armed by a settled high, spent by one fall
  always_comb begin
    next_skip_first = skip_first;
    if (next_state != ST_ACTIVE) begin
      next_skip_first = 1'b1; // R11
    end else if (rearm) begin
      next_skip_first = 1'b1; // R11
    end else if (fall) begin
      next_skip_first = 1'b0; // R11
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state <= ST_SLEEP; // R2
      level <= LEVEL_RESET;
      dir_up <= 1'b0;
      skip_first <= 1'b1;
    end else begin
      state <= next_state;
      level <= next_level; // R15
      dir_up <= next_dir_up;
      skip_first <= next_skip_first;
    end
  end

  // Output flops follow the next state
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      boost_enable <= 1'b0;
      led_drive_enable <= 1'b0;
      led_current_code <= '0;
    end else begin
      boost_enable <= (next_state == ST_ACTIVE); // R7
      led_drive_enable <= (next_state == ST_ACTIVE); // R24
      led_current_code <= (next_state == ST_ACTIVE) ? CURRENT_CODE[next_level] : '0; // R21
    end
  end

  // Level and direction are plain register copies
  assign brightness_level = level; // R16
  assign count_up = dir_up;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_sleep_hold;
    is_sleep && pin_low |=> is_sleep;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) // R2
    else $error("shutdown left while pin low");

  property p_long_low;
    pin_low && !fall && (phase == SLEEP_LIM) |=> !led_drive_enable && !boost_enable
      && (brightness_level == LEVEL_RESET) && !count_up;
  endproperty
  a_long_low: assert property (p_long_low) // R6
    else $error("long low did not shut down");

  property p_sleep_dark;
    is_sleep |-> !led_drive_enable && !boost_enable && led_current_code == '0;
  endproperty
  a_sleep_dark: assert property (p_sleep_dark) // R7
    else $error("LEDs driven in shutdown");

  property p_start_full;
    is_setup && on_ready && !long_low |=> led_drive_enable
      && brightness_level == LEVEL_RESET && !count_up;
  endproperty
  a_start_full: assert property (p_start_full) // R4
    else $error("default start not at full level");

  property p_on_wait;
    $rose(led_drive_enable) |-> $past(pin_high) && ($past(phase) >= ON_LIM);
  endproperty
  a_on_wait: assert property (p_on_wait) // R24
    else $error("LEDs enabled before high wait");

  property p_dir_up;
    is_active && up_pulse |=> count_up ##1 count_up || $past(dn_pulse) || $past(long_low);
  endproperty
  a_dir_up: assert property (p_dir_up) // R8
    else $error("raise pulse did not select up");

  property p_dir_down;
    is_active && dn_pulse |=> !count_up;
  endproperty
  a_dir_down: assert property (p_dir_down) // R9
    else $error("lower pulse did not select down");

  property p_dir_kept;
    is_active && rise && !up_pulse && !dn_pulse |=> $stable(count_up);
  endproperty
  a_dir_kept: assert property (p_dir_kept) // R25
    else $error("odd low phase changed direction");

  property p_skip;
    is_active && fall && skip_first && !long_low |=> $stable(brightness_level);
  endproperty
  a_skip: assert property (p_skip) // R11
    else $error("first edge was counted");

  property p_step_down;
    is_active && fall && !skip_first && !dir_up
      |=> brightness_level == $past(brightness_level) - 4'h1;
  endproperty
  a_step_down: assert property (p_step_down) // R17
    else $error("down step or wrap wrong");

  property p_step_up;
    is_active && fall && !skip_first && dir_up && (level == 4'hf)
      |=> brightness_level == 4'h0;
  endproperty
  a_step_up: assert property (p_step_up) // R18
    else $error("up wrap to zero missing");

  property p_preset_down;
    is_preset && fall |=> brightness_level == $past(brightness_level) - 4'h1 && !count_up;
  endproperty
  a_preset_down: assert property (p_preset_down) // R23
    else $error("preset edge not counted down");

  property p_hold_high;
    (is_active && pin_high) [*8] |=> $stable(brightness_level);
  endproperty
  a_hold_high: assert property (p_hold_high) // R15
    else $error("level drifted while pin high");

  property p_code_match;
    led_drive_enable |-> led_current_code == CURRENT_CODE[brightness_level];
  endproperty
  a_code_match: assert property (p_code_match) // R21
    else $error("current code does not match level");

  property p_step_up_one;
    is_active && fall && !skip_first && dir_up
      |=> brightness_level == $past(brightness_level) + 4'h1;
  endproperty
  a_step_up_one: assert property (p_step_up_one) // R12
    else $error("up step wrong");

  property p_dir_no_rearm;
    is_active && rise && !skip_first |=> !skip_first;
  endproperty
  a_dir_no_rearm: assert property (p_dir_no_rearm) // R19 R20
    else $error("direction pulse re-armed the ignored edge");

  property p_fall_stays_on;
    is_active && fall |=> is_active;
  endproperty
  a_fall_stays_on: assert property (p_fall_stays_on) // R1
    else $error("fall after long high left driving state");
endmodule
`default_nettype wire

// *** verification/pin_host.sv ***
// Controller model driving the single control pin
`timescale 1ns/1ps
`default_nettype none
module pin_host #(
  parameter int unsigned TICK = 4
) (
  input wire logic core_clk,
  output logic serial_control_pin
);
  initial serial_control_pin = 1'b0;

  // -------------------------------------------------
  // Pin drive tasks
  // -------------------------------------------------
  // Change just after a falling edge, hold for whole microseconds
  task automatic drive(input logic v, input int unsigned us);
    @(negedge core_clk);
    serial_control_pin = v;
    repeat (us * TICK - 1) @(negedge core_clk);
  endtask

  // Programming pulse, both phases kept within 2 to 32 us
  task automatic prog(input int unsigned lo, input int unsigned hi);
    drive(1'b0, (lo < 2) ? 2 : (lo > 32) ? 32 : lo);
    drive(1'b1, (hi < 2) ? 2 : (hi > 32) ? 32 : hi);
  endtask

  // Direction pulse after a long enough high
  task automatic dir(input int unsigned us, input int unsigned hi);
    drive(1'b1, 140);
    drive(1'b0, us);
    drive(1'b1, hi);
  endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking testbench for the brightness link
`timescale 1ns/1ps
`default_nettype none
module tb;
  import brightness_pkg::*;

  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  wire logic serial_control_pin;
  logic boost_enable;
  logic led_drive_enable;
  logic count_up;
  logic [LEVEL_W-1:0] brightness_level;
  logic [CODE_W-1:0] led_current_code;
  int lvl = 15;
  int up = 0;
  int skip = 1;
  int act = 0;
  int k;
  int n_errors = 0;
  int n_compared = 0;

  // Clock, 4 ns period
  always #2 core_clk = ~core_clk;

  brightness_link #(.TICK_CYCLES(4)) brightness_link_i (
    .core_clk(core_clk),
    .nrst(nrst),
    .serial_control_pin(serial_control_pin),
    .boost_enable(boost_enable),
    .led_drive_enable(led_drive_enable),
    .count_up(count_up),
    .brightness_level(brightness_level),
    .led_current_code(led_current_code)
  );

  pin_host #(.TICK(4)) pin_host_i (
    .core_clk(core_clk),
    .serial_control_pin(serial_control_pin)
  );

  // -------------------------------------------------
  // Compare and report
  // -------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic check_all();
    check(8'(brightness_level), 8'(lvl));
    check(8'(count_up), 8'(up));
    check(8'(led_drive_enable), 8'(act));
    check(8'(boost_enable), 8'(act));
    check(led_current_code, (act != 0) ? CURRENT_CODE[lvl] : 8'h00);
  endtask

  task automatic end_sim();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // -------------------------------------------------
  // Reference model steps
  // -------------------------------------------------
  // One fall: first after re-arm is skipped, else one wrapping step
  task automatic step();
    if (skip != 0) begin
      skip = 0;
    end else begin
      lvl = (up != 0) ? (lvl + 1) % 16 : (lvl + 15) % 16;
    end
  endtask

  task automatic burst(input int n);
    repeat (n) begin
      pin_host_i.prog(2 + $urandom % 31, 2 + $urandom % 31);
      step();
    end
  endtask

  // Long high re-arms the skip and must keep the level
  task automatic settle();
    pin_host_i.drive(1'b1, 150);
    skip = 1;
    check_all();
  endtask

  task automatic direction(input int unsigned us);
    pin_host_i.dir(us, 2 + $urandom % 31);
    skip = 0;
    if (us inside {[100:160]}) begin
      up = 1;
    end
    if (us inside {[420:500]}) begin
      up = 0;
    end
  endtask

  // Watchdog
  initial begin
    repeat (80000) @(posedge core_clk);
    n_errors++;
    end_sim();
  end

  // -------------------------------------------------
  // Main sequence
  // -------------------------------------------------
  initial begin
    void'($urandom(84));
    repeat (12) @(negedge core_clk);
    nrst = 1'b1;
    repeat (4) @(negedge core_clk);
    check_all();
    // Default start-up
    pin_host_i.drive(1'b1, 130);
    check_all();
    pin_host_i.drive(1'b1, 20);
    act = 1;
    check_all();
    // Burst down, then wrap below zero
    burst(2 + $urandom % 4);
    settle();
    burst(lvl + 2);
    settle();
    // Raise direction, one step, then wrap above fifteen
    direction(130);
    burst(1);
    settle();
    burst(15 - lvl + 2);
    settle();
    // Unlisted low length keeps direction
    direction(300);
    settle();
    direction(460);
    burst(1);
    settle();
    repeat (3) begin
      direction(($urandom % 2 != 0) ? 102 + $urandom % 57 : 422 + $urandom % 77);
      burst(1 + $urandom % 5);
      settle();
    end
    // Shutdown drops everything
    pin_host_i.drive(1'b0, 1300);
    act = 0;
    lvl = 15;
    up = 0;
    check_all();
    // Preset start-up
    k = $urandom % 6;
    pin_host_i.drive(1'b1, 40);
    repeat (k) pin_host_i.prog(2 + $urandom % 9, 2 + $urandom % 9);
    pin_host_i.drive(1'b0, 5);
    lvl = 15 - (k + 1);
    pin_host_i.drive(1'b1, 130);
    check(8'(led_drive_enable), 8'h00);
    pin_host_i.drive(1'b1, 20);
    act = 1;
    check_all();
    end_sim();
  end
endmodule
`default_nettype wire
